// >>> issu_pkg.sv
/*
  Constants and types shared by the integer shift and subtract unit.
  Assumes it is compiled before any file that names it.
*/
package issu_pkg;

  // Instruction word layout.
  localparam int MAJOR_MSB = 31;
  localparam int MAJOR_LSB = 26;
  localparam int FIELD_B_MSB = 25;
  localparam int FIELD_B_LSB = 21;
  localparam int FIELD_A_MSB = 20;
  localparam int FIELD_A_LSB = 16;
  localparam int FIELD_D_MSB = 15;
  localparam int FIELD_D_LSB = 11;
  localparam int ZERO_BIT = 10;
  localparam int FUNC_MSB = 9;
  localparam int FUNC_LSB = 0;
  localparam int SIGN_BIT = 31;
  localparam int AMT_MSB = 4;

  // Major group and function codes.
  localparam logic [5:0] MAJOR_GROUP_ZERO = 6'h00;
  localparam logic [9:0] FUNC_SHIFT_RIGHT_ARITH_IMM = 10'h080;
  localparam logic [9:0] FUNC_SHIFT_RIGHT_ARITH_VAR = 10'h090;
  localparam logic [9:0] FUNC_SHIFT_RIGHT_LOGIC_IMM = 10'h040;
  localparam logic [9:0] FUNC_SHIFT_RIGHT_LOGIC_VAR = 10'h050;
  localparam logic [9:0] FUNC_SUBTRACT_MODULO = 10'h1d0;
  localparam logic [9:0] FUNC_SUBTRACT_TRAP = 10'h190;

  // Values after reset and latency.
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam int RESULT_LATENCY_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ARITH_IMM = 3'h1,
    OP_ARITH_VAR = 3'h3,
    OP_LOGIC_IMM = 3'h2,
    OP_LOGIC_VAR = 3'h6,
    OP_SUB_MOD = 3'h7,
    OP_SUB_TRAP = 3'h5
  } issu_op_t;

endpackage

// >>> issu_unit.sv
/*
  Integer right shift and word subtract datapath with a one-cycle registered result.
  Assumes the pipeline reads both source registers from the instruction's fields and
  presents their values together with the instruction word on the same clock edge.
*/
//
// Behaviour
// - Arithmetic right shift by immediate fills vacated upper bits with bit 31.
// - Variable arithmetic right shift sign-fills the second source and writes the third field.
// - Logical right shift by immediate fills vacated upper bits with zero.
// - Variable logical right shift zero-fills the second source and writes the third field.
// - Variable shifts take their distance from the low five bits of the first source.
// - Immediate shifts take their distance from the shift amount field and write field B.
// - Shifts act on the low 32-bit word and a distance of zero passes it unchanged.
// - Trapping subtract that overflows leaves the destination alone and raises the exception.
// - Trapping subtract without overflow writes first source minus second source.
// - Overflow is bit 32 differing from bit 31 of the 33-bit sign-extended difference.
// - Modulo subtract always writes the wrapped difference and never raises an exception.
// - Both subtracts compute the second source word taken from the first.
// - Only the trapping subtract may raise an exception.
`timescale 1ns/100ps

module issu_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Instruction and operands
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_value,
  input wire logic [31:0] src_b_value,
  // Result toward the register file
  output logic result_valid,
  output logic [31:0] result_data,
  output logic write_en,
  output logic [4:0] write_index,
  // Exception and decode status
  output logic overflow_exc,
  output logic unknown_op
);

  issu_pkg::issu_op_t dec_op;
  logic [4:0] field_b;
  logic [4:0] field_d;
  logic [4:0] shift_amount_field;
  logic [32:0] diff_wide;
  logic diff_ovf;
  logic [31:0] sh_word;
  logic [4:0] sh_amt;
  logic sh_arith;
  logic [31:0] sh_res;

  logic result_valid_r, result_valid_nxt;
  logic [31:0] result_data_r, result_data_nxt;
  logic write_en_r, write_en_nxt;
  logic [4:0] write_index_r, write_index_nxt;
  logic overflow_exc_r, overflow_exc_nxt;
  logic unknown_op_r, unknown_op_nxt;

  // Decodes the operation and register fields.
  always_comb begin
    field_b = instr_word[issu_pkg::FIELD_B_MSB:issu_pkg::FIELD_B_LSB];
    field_d = instr_word[issu_pkg::FIELD_D_MSB:issu_pkg::FIELD_D_LSB];
    shift_amount_field = field_d;
    dec_op = issu_pkg::OP_NONE;
    if (instr_word[issu_pkg::MAJOR_MSB:issu_pkg::MAJOR_LSB] == issu_pkg::MAJOR_GROUP_ZERO &&
        !instr_word[issu_pkg::ZERO_BIT]) begin
      case (instr_word[issu_pkg::FUNC_MSB:issu_pkg::FUNC_LSB])
        issu_pkg::FUNC_SHIFT_RIGHT_ARITH_IMM: dec_op = issu_pkg::OP_ARITH_IMM;
        issu_pkg::FUNC_SHIFT_RIGHT_ARITH_VAR: dec_op = issu_pkg::OP_ARITH_VAR;
        issu_pkg::FUNC_SHIFT_RIGHT_LOGIC_IMM: dec_op = issu_pkg::OP_LOGIC_IMM;
        issu_pkg::FUNC_SHIFT_RIGHT_LOGIC_VAR: dec_op = issu_pkg::OP_LOGIC_VAR;
        issu_pkg::FUNC_SUBTRACT_MODULO: dec_op = issu_pkg::OP_SUB_MOD;
        issu_pkg::FUNC_SUBTRACT_TRAP: dec_op = issu_pkg::OP_SUB_TRAP;
        default: dec_op = issu_pkg::OP_NONE;
      endcase
    end
  end

  // Shared shifter and subtractor.
  always_comb begin
    sh_arith = (dec_op == issu_pkg::OP_ARITH_IMM) || (dec_op == issu_pkg::OP_ARITH_VAR);
    if (dec_op == issu_pkg::OP_ARITH_VAR || dec_op == issu_pkg::OP_LOGIC_VAR) begin
      sh_word = src_b_value;
      sh_amt = src_a_value[issu_pkg::AMT_MSB:0];
    end else begin
      sh_word = src_a_value;
      sh_amt = shift_amount_field;
    end
    if (sh_arith) begin
      sh_res = 32'($signed(sh_word) >>> sh_amt);
    end else begin
      sh_res = sh_word >> sh_amt;
    end
    diff_wide = {src_a_value[issu_pkg::SIGN_BIT], src_a_value} -
                {src_b_value[issu_pkg::SIGN_BIT], src_b_value};
    diff_ovf = diff_wide[32] != diff_wide[issu_pkg::SIGN_BIT];
  end

  // Next result, write and exception values.
  always_comb begin
    result_valid_nxt = 1'b0;
    result_data_nxt = issu_pkg::RESULT_RESET;
    write_en_nxt = 1'b0;
    write_index_nxt = issu_pkg::INDEX_RESET;
    overflow_exc_nxt = 1'b0;
    unknown_op_nxt = 1'b0;
    if (instr_valid) begin
      case (dec_op)
        issu_pkg::OP_ARITH_IMM, issu_pkg::OP_LOGIC_IMM: begin
          result_valid_nxt = 1'b1;
          result_data_nxt = sh_res;
          write_en_nxt = 1'b1;
          write_index_nxt = field_b;
        end
        issu_pkg::OP_ARITH_VAR, issu_pkg::OP_LOGIC_VAR: begin
          result_valid_nxt = 1'b1;
          result_data_nxt = sh_res;
          write_en_nxt = 1'b1;
          write_index_nxt = field_d;
        end
        issu_pkg::OP_SUB_MOD: begin
          result_valid_nxt = 1'b1;
          result_data_nxt = diff_wide[31:0];
          write_en_nxt = 1'b1;
          write_index_nxt = field_d;
        end
        issu_pkg::OP_SUB_TRAP: begin
          result_valid_nxt = 1'b1;
          result_data_nxt = diff_wide[31:0];
          write_en_nxt = !diff_ovf;
          write_index_nxt = field_d;
          overflow_exc_nxt = diff_ovf;
        end
        default: begin
          unknown_op_nxt = 1'b1;
        end
      endcase
    end
  end

  // Registers the result one cycle after the operands.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_valid_r <= 1'b0;
      result_data_r <= issu_pkg::RESULT_RESET;
      write_en_r <= 1'b0;
      write_index_r <= issu_pkg::INDEX_RESET;
      overflow_exc_r <= 1'b0;
      unknown_op_r <= 1'b0;
    end else begin
      result_valid_r <= result_valid_nxt;
      result_data_r <= result_data_nxt;
      write_en_r <= write_en_nxt;
      write_index_r <= write_index_nxt;
      overflow_exc_r <= overflow_exc_nxt;
      unknown_op_r <= unknown_op_nxt;
    end
  end

  assign result_valid = result_valid_r;
  assign result_data = result_data_r;
  assign write_en = write_en_r;
  assign write_index = write_index_r;
  assign overflow_exc = overflow_exc_r;
  assign unknown_op = unknown_op_r;

  // Checks on the registered outputs.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_arith_imm;
    instr_valid && dec_op == issu_pkg::OP_ARITH_IMM;
  endsequence
  sequence s_arith_var;
    instr_valid && dec_op == issu_pkg::OP_ARITH_VAR;
  endsequence
  sequence s_logic_imm;
    instr_valid && dec_op == issu_pkg::OP_LOGIC_IMM;
  endsequence
  sequence s_logic_var;
    instr_valid && dec_op == issu_pkg::OP_LOGIC_VAR;
  endsequence
  sequence s_sub_trap;
    instr_valid && dec_op == issu_pkg::OP_SUB_TRAP;
  endsequence
  sequence s_sub_mod;
    instr_valid && dec_op == issu_pkg::OP_SUB_MOD;
  endsequence

  a_arith_sign_fill: assert property (s_arith_imm |=>
    result_data[31] == $past(src_a_value[31]) && write_en && !overflow_exc)
    else $error("Arithmetic shift lost the sign bit.");
  a_arith_var_dest: assert property (s_arith_var |=>
    result_data[31] == $past(src_b_value[31]) && write_index == $past(field_d))
    else $error("Variable arithmetic shift wrong sign or destination.");
  a_logic_zero_top: assert property (s_logic_imm ##0 (shift_amount_field != 5'h00) |=>
    !result_data[31])
    else $error("Logical shift did not zero the top bit.");
  a_logic_var_fill: assert property (s_logic_var ##0 (src_a_value[4:0] != 5'h00) |=>
    !result_data[31] && write_index == $past(field_d))
    else $error("Variable logical shift wrong fill or destination.");
  a_var_low_amount: assert property (s_logic_var |=>
    result_data == ($past(src_b_value) >> $past(src_a_value[4:0])))
    else $error("Variable shift used the wrong distance.");
  a_imm_amount_dest: assert property (s_logic_imm |=>
    result_data == ($past(src_a_value) >> $past(shift_amount_field)) &&
    write_index == $past(field_b))
    else $error("Immediate shift wrong distance or destination.");
  a_zero_shift_pass: assert property (s_arith_imm ##0 (shift_amount_field == 5'h00) |=>
    result_data == $past(src_a_value))
    else $error("Zero distance shift changed the word.");
  a_trap_no_write: assert property (s_sub_trap ##0 diff_ovf |=>
    overflow_exc && !write_en && result_valid)
    else $error("Overflowing subtract wrote the destination.");
  a_trap_difference: assert property (s_sub_trap ##0 !diff_ovf |=>
    write_en && !overflow_exc && result_data == 32'($past(src_a_value) - $past(src_b_value)))
    else $error("Trapping subtract wrote a wrong difference.");
  a_ovf_sign_rule: assert property (s_sub_trap |=>
    overflow_exc == (($past(src_a_value[31]) != $past(src_b_value[31])) &&
    (result_data[31] != $past(src_a_value[31]))))
    else $error("Overflow flag disagrees with operand signs.");
  a_modulo_no_trap: assert property (s_sub_mod |=>
    write_en && !overflow_exc &&
    result_data == 32'($past(src_a_value) - $past(src_b_value)))
    else $error("Modulo subtract trapped or wrote a wrong value.");
  a_exc_only_sub: assert property (overflow_exc |->
    $past(instr_valid) && $past(dec_op) == issu_pkg::OP_SUB_TRAP)
    else $error("Exception raised by a non-trapping operation.");
  a_one_cycle_result: assert property (
    instr_valid && dec_op != issu_pkg::OP_NONE |=> result_valid ##1
    (result_valid == $past(instr_valid && dec_op != issu_pkg::OP_NONE)))
    else $error("Result did not arrive one cycle after its operands.");
  a_ovf_blocks_write: assert property (overflow_exc |-> !write_en)
    else $error("Write enabled together with overflow.");

endmodule // issu_unit

// >>> issu_regfile_model.sv
/*
  Register file model that feeds operands to the shift and subtract unit and takes its results.
  Assumes one write per clock and no read of a register written in the same cycle.
*/
`timescale 1ns/100ps

module issu_regfile_model (
  // Clock
  input wire logic ref_clk,
  // Instruction and operands
  input wire logic [31:0] instr_word,
  output logic [31:0] src_a_value,
  output logic [31:0] src_b_value,
  // Results and exceptions
  input wire logic write_en,
  input wire logic [4:0] write_index,
  input wire logic [31:0] result_data,
  input wire logic overflow_exc,
  output int exc_count
);
  logic [31:0] regs [32];

  // Operands follow the register fields of the word presented.
  assign src_a_value = regs[instr_word[20:16]];
  assign src_b_value = regs[instr_word[25:21]];

  initial exc_count = 0;

  always @(posedge ref_clk) begin
    if (write_en) begin
      regs[write_index] <= result_data;
    end
    if (overflow_exc) begin
      exc_count <= exc_count + 1;
    end
  end
endmodule // issu_regfile_model

// >>> issu_unit_bench.sv
/*
  Self-checking bench for the shift and subtract unit.
  Assumes the register file model supplies operands and stores results.
*/
`timescale 1ns/100ps

module issu_unit_bench;
  logic ref_clk, reset, instr_valid, result_valid, write_en, overflow_exc, unknown_op;
  logic [31:0] instr_word, src_a_value, src_b_value, result_data;
  logic [4:0] write_index;
  int exc_count, fail_count, n_compared;

  issu_unit dut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .src_a_value(src_a_value), .src_b_value(src_b_value),
    .result_valid(result_valid), .result_data(result_data), .write_en(write_en),
    .write_index(write_index), .overflow_exc(overflow_exc), .unknown_op(unknown_op));

  issu_regfile_model pm (.ref_clk(ref_clk), .instr_word(instr_word),
    .src_a_value(src_a_value), .src_b_value(src_b_value), .write_en(write_en),
    .write_index(write_index), .result_data(result_data), .overflow_exc(overflow_exc),
    .exc_count(exc_count));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] mk(input logic [9:0] f, input logic [4:0] b,
    input logic [4:0] a, input logic [4:0] d);
    return {issu_pkg::MAJOR_GROUP_ZERO, b, a, d, 1'b0, f};
  endfunction

  // Presents one word and judges the answer one cycle later; valid stays high.
  task automatic exec(input logic [31:0] w, input logic [31:0] exp, input logic wr,
    input logic [4:0] idx, input logic ovf);
    instr_valid = 1'b1;
    instr_word = w;
    repeat (issu_pkg::RESULT_LATENCY_CYCLES) @(posedge ref_clk);
    #1;
    chk("result_valid", 32'h1, {31'h0, result_valid});
    chk("result_data", exp, result_data);
    chk("write_en", {31'h0, wr}, {31'h0, write_en});
    chk("write_index", {27'h0, idx}, {27'h0, write_index});
    chk("overflow_exc", {31'h0, ovf}, {31'h0, overflow_exc});
    chk("unknown_op", 32'h0, {31'h0, unknown_op});
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("idle result_valid", 32'h0, {31'h0, result_valid});
    chk("idle write_en", 32'h0, {31'h0, write_en});
    chk("idle overflow_exc", 32'h0, {31'h0, overflow_exc});
  endtask

  // Back-to-back shifts of a negative word over boundary distances.
  task automatic t_shift();
    logic [4:0] amt [4] = '{5'h00, 5'h01, 5'h0d, 5'h1f};
    logic [31:0] v;
    logic [31:0] ar;
    v = 32'h8765_4321;
    pm.regs[2] = v;
    for (int i = 0; i < 4; i++) begin
      ar = (v >> amt[i]) | (v[31] ? ~(32'hffff_ffff >> amt[i]) : 32'h0);
      pm.regs[4] = {27'h5abcde0, amt[i]};
      exec(mk(issu_pkg::FUNC_SHIFT_RIGHT_ARITH_IMM, 5'h06, 5'h02, amt[i]), ar, 1, 6, 0);
      exec(mk(issu_pkg::FUNC_SHIFT_RIGHT_LOGIC_IMM, 5'h07, 5'h02, amt[i]), v >> amt[i], 1, 7, 0);
      exec(mk(issu_pkg::FUNC_SHIFT_RIGHT_ARITH_VAR, 5'h02, 5'h04, 5'h08), ar, 1, 8, 0);
      exec(mk(issu_pkg::FUNC_SHIFT_RIGHT_LOGIC_VAR, 5'h02, 5'h04, 5'h09), v >> amt[i], 1, 9, 0);
    end
    idle();
    chk("shift write back", v >> 31, pm.regs[9]);
    $display("shift test done");
  endtask

  // Both subtracts at and across the overflow boundary.
  task automatic t_sub();
    pm.regs[10] = 32'h8000_0000;
    pm.regs[11] = 32'h0000_0001;
    pm.regs[12] = 32'h7fff_ffff;
    pm.regs[13] = 32'hffff_ffff;
    pm.regs[20] = 32'h1234_5678;
    exec(mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0b, 5'h0c, 5'h15), 32'h7fff_fffe, 1, 21, 0);
    exec(mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0b, 5'h0a, 5'h14), 32'h7fff_ffff, 0, 20, 1);
    exec(mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0d, 5'h0c, 5'h14), 32'h8000_0000, 0, 20, 1);
    exec(mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0c, 5'h0d, 5'h16), 32'h8000_0000, 1, 22, 0);
    exec(mk(issu_pkg::FUNC_SUBTRACT_MODULO, 5'h0b, 5'h0a, 5'h17), 32'h7fff_ffff, 1, 23, 0);
    idle();
    chk("kept destination", 32'h1234_5678, pm.regs[20]);
    chk("modulo write back", 32'h7fff_ffff, pm.regs[23]);
    chk("exception count", 32'h2, 32'(exc_count));
    $display("subtract test done");
  endtask

  // Words outside the handled set write nothing and raise no exception.
  task automatic t_unknown();
    logic [31:0] bad [3];
    bad[0] = mk(10'h3ff, 5'h01, 5'h02, 5'h03);
    bad[1] = mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0b, 5'h0a, 5'h03) | 32'h0400_0000;
    bad[2] = mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0b, 5'h0a, 5'h03) | 32'h0000_0400;
    for (int i = 0; i < 3; i++) begin
      instr_valid = 1'b1;
      instr_word = bad[i];
      @(posedge ref_clk);
      #1;
      chk("unknown_op", 32'h1, {31'h0, unknown_op});
      chk("bad result_valid", 32'h0, {31'h0, result_valid});
      chk("bad write_en", 32'h0, {31'h0, write_en});
      chk("bad overflow_exc", 32'h0, {31'h0, overflow_exc});
    end
    idle();
    $display("unknown test done");
  endtask

  // Reset in mid-run drops an instruction that is under way.
  task automatic t_reset();
    instr_valid = 1'b1;
    instr_word = mk(issu_pkg::FUNC_SUBTRACT_TRAP, 5'h0b, 5'h0a, 5'h14);
    reset = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("reset result_valid", 32'h0, {31'h0, result_valid});
    chk("reset write_en", 32'h0, {31'h0, write_en});
    chk("reset overflow_exc", 32'h0, {31'h0, overflow_exc});
    chk("reset result_data", issu_pkg::RESULT_RESET, result_data);
    chk("reset write_index", {27'h0, issu_pkg::INDEX_RESET}, {27'h0, write_index});
    reset = 1'b0;
    exec(instr_word, 32'h7fff_ffff, 1'b0, 5'h14, 1'b1);
    idle();
    $display("reset test done");
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    $display("Error watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    fail_count = 0;
    n_compared = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    idle();
    t_shift();
    t_sub();
    t_unknown();
    t_reset();
    tally_and_finish();
  end
endmodule // issu_unit_bench
